// ==== core/nand_host_pkg.sv ====
package nand_host_pkg;
    // Array organisation
    localparam int PAGES_PER_BLOCK = 64;
    localparam int MAIN_BYTES = 2048;
    localparam int SPARE_BYTES = 64;
    localparam int MAIN_WORDS = 1024;
    localparam int SPARE_WORDS = 32;
    localparam int BLOCKS_1G = 1024;
    localparam int BLOCKS_2G = 2048;
    localparam int MIN_VALID_1G = 1004;
    localparam int MIN_VALID_2G = 2008;
    localparam int ADDR_CYCLES_1G = 4;
    localparam int ADDR_CYCLES_2G = 5;
    // Timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int RECOVERY_US = 10;
    localparam int RECOVERY_CYCLES = (RECOVERY_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int GLITCH_NS = 5;
    // Strobe phase length, kept well above the ignored glitch width
    localparam int PHASE_CYCLES = (GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
    localparam logic [3:0] PHASE_W = 4'(PHASE_CYCLES);
    // Request kinds
    typedef enum logic [1:0] {
        OP_COMMAND,
        OP_ADDRESS,
        OP_WRITE,
        OP_READ
    } op_type;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
endpackage

// ==== core/nand_pin_if.sv ====
interface nand_pin_if;
    import nand_host_pkg::*;
    logic cs_n;
    logic command_latch_strobe;
    logic address_latch_strobe;
    logic we_n;
    logic re_n;
    logic [15:0] lanes_out;
    logic lanes_oe;
    modport drive (output cs_n, command_latch_strobe, address_latch_strobe, we_n, re_n, lanes_out, lanes_oe);
    modport pins (input cs_n, command_latch_strobe, address_latch_strobe, we_n, re_n, lanes_out, lanes_oe);
endinterface

// ==== core/nand_recovery_timer.sv ====
module nand_recovery_timer #(
    parameter int COUNT = nand_host_pkg::RECOVERY_CYCLES
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // Status
    output logic done_o
);
    import nand_host_pkg::*;
    typedef struct packed {
        logic [31:0] cnt;
        logic done;
    } tmr_type;
    tmr_type st_r;
    tmr_type st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (!st_r.done) begin
            if (st_r.cnt >= 32'(COUNT - 1)) begin
                st_nxt.done = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + 32'd1;
            end
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign done_o = st_r.done;

    a_recovery_len: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        $rose(st_r.done) |-> st_r.cnt == 32'(COUNT - 1))
        else $error("recovery finished at wrong count");
endmodule

// ==== core/nand_host_ctrl.sv ====
module nand_host_ctrl #(
    parameter int RECOVERY = nand_host_pkg::RECOVERY_CYCLES
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // Request side
    input wire logic req_valid_i,
    input wire nand_host_pkg::op_type req_op_i,
    input wire logic [15:0] req_data_i,
    input wire logic req_last_i,
    input wire logic wide_i,
    output logic req_ready_o,
    output logic rd_valid_o,
    output logic [15:0] rd_data_o,
    output logic ready_o,
    // Protection control
    input wire logic protect_i,
    // Device pins
    output logic cs_n_o,
    output logic command_latch_strobe_o,
    output logic address_latch_strobe_o,
    output logic we_n_o,
    output logic re_n_o,
    output logic write_protect_n_o,
    output logic [15:0] lanes_o,
    output logic lanes_oe_o,
    input wire logic [15:0] lanes_i,
    input wire logic ready_busy_n_i
);
    import nand_host_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin bundle and power-up recovery

    nand_pin_if pin_bus ();
    logic recovered;

    nand_recovery_timer #(
        .COUNT(RECOVERY)
    ) u_recovery (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .done_o(recovered)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state

    typedef enum logic [2:0] {
        S_POWERUP,
        S_IDLE,
        S_SETUP,
        S_STROBE,
        S_HOLD
    } state_type;

    typedef struct packed {
        state_type state;
        op_type op;
        logic [3:0] cnt;
        logic cs_n;
        logic cle;
        logic ale;
        logic we_n;
        logic re_n;
        logic [15:0] dout;
        logic oe;
        logic last;
        logic wide;
        logic rd_valid;
        logic [15:0] rd_data;
    } ctrl_type;

    ctrl_type st_r;
    ctrl_type st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.rd_valid = 1'b0;
        unique case (st_r.state)
            S_POWERUP: begin
                // Device not ready for commands during recovery
                if (recovered && ready_busy_n_i) begin
                    st_nxt.state = S_IDLE;
                end
            end
            S_IDLE: begin
                if (req_valid_i) begin
                    st_nxt.op = req_op_i;
                    st_nxt.last = req_last_i;
                    st_nxt.wide = wide_i;
                    st_nxt.cs_n = 1'b0;
                    st_nxt.cle = (req_op_i == OP_COMMAND);
                    // Address cycle count is the requester's duty, one byte per request
                    st_nxt.ale = (req_op_i == OP_ADDRESS);
                    st_nxt.oe = (req_op_i != OP_READ);
                    // Commands and addresses only on the low byte lanes
                    if (req_op_i == OP_WRITE && wide_i) begin
                        st_nxt.dout = req_data_i;
                    end else begin
                        st_nxt.dout = {ZERO_BYTE, req_data_i[7:0]};
                    end
                    st_nxt.cnt = PHASE_W;
                    st_nxt.state = S_SETUP;
                end
            end
            S_SETUP: begin
                if (st_r.cnt == 4'd1) begin
                    // Strobe low phase longer than the ignored glitch width
                    if (st_r.op == OP_READ) begin
                        st_nxt.re_n = 1'b0;
                    end else begin
                        st_nxt.we_n = 1'b0;
                    end
                    st_nxt.cnt = PHASE_W;
                    st_nxt.state = S_STROBE;
                end else begin
                    st_nxt.cnt = st_r.cnt - 4'd1;
                end
            end
            S_STROBE: begin
                if (st_r.cnt == 4'd1) begin
                    if (st_r.op == OP_READ) begin
                        st_nxt.rd_valid = 1'b1;
                        st_nxt.rd_data = st_r.wide ? lanes_i : {ZERO_BYTE, lanes_i[7:0]};
                    end
                    // Rising we_n edge latches command, address and write cycles in the device; the read word is already captured here
                    st_nxt.we_n = 1'b1;
                    st_nxt.re_n = 1'b1;
                    st_nxt.cnt = PHASE_W;
                    st_nxt.state = S_HOLD;
                end else begin
                    st_nxt.cnt = st_r.cnt - 4'd1;
                end
            end
            S_HOLD: begin
                if (st_r.cnt == 4'd1) begin
                    st_nxt.cle = 1'b0;
                    st_nxt.ale = 1'b0;
                    st_nxt.oe = 1'b0;
                    st_nxt.dout = ZERO_WORD;
                    // Select kept low between cycles of one operation
                    st_nxt.cs_n = st_r.last;
                    st_nxt.state = S_IDLE;
                end else begin
                    st_nxt.cnt = st_r.cnt - 4'd1;
                end
            end
            default: st_nxt.state = S_POWERUP;
        endcase
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r <= '{state: S_POWERUP, op: OP_COMMAND, cnt: 4'd0, cs_n: 1'b1, cle: 1'b0, ale: 1'b0,
                      we_n: 1'b1, re_n: 1'b1, dout: ZERO_WORD, oe: 1'b0, last: 1'b1, wide: 1'b0,
                      rd_valid: 1'b0, rd_data: ZERO_WORD};
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign pin_bus.cs_n = st_r.cs_n;
    assign pin_bus.command_latch_strobe = st_r.cle;
    assign pin_bus.address_latch_strobe = st_r.ale;
    assign pin_bus.we_n = st_r.we_n;
    assign pin_bus.re_n = st_r.re_n;
    assign pin_bus.lanes_out = st_r.dout;
    assign pin_bus.lanes_oe = st_r.oe;

    assign cs_n_o = pin_bus.cs_n;
    assign command_latch_strobe_o = pin_bus.command_latch_strobe;
    assign address_latch_strobe_o = pin_bus.address_latch_strobe;
    assign we_n_o = pin_bus.we_n;
    assign re_n_o = pin_bus.re_n;
    assign lanes_o = pin_bus.lanes_out;
    assign lanes_oe_o = pin_bus.lanes_oe;
    // Protect pin is not sequenced, it follows software directly once recovery is done and is held low before that
    assign write_protect_n_o = !protect_i && recovered;
    assign req_ready_o = (st_r.state == S_IDLE);
    assign rd_valid_o = st_r.rd_valid;
    assign rd_data_o = st_r.rd_data;
    assign ready_o = (st_r.state == S_IDLE) && ready_busy_n_i;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    a_no_early_cmd: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !recovered |-> cs_n_o && we_n_o)
        else $error("bus touched during recovery");
    a_cmd_levels: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (st_r.op == OP_COMMAND && !we_n_o) |-> !cs_n_o && command_latch_strobe_o
        && !address_latch_strobe_o && re_n_o)
        else $error("command cycle levels wrong");
    a_addr_levels: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (st_r.op == OP_ADDRESS && !we_n_o) |-> !cs_n_o && address_latch_strobe_o
        && !command_latch_strobe_o && re_n_o)
        else $error("address cycle levels wrong");
    a_write_levels: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (st_r.op == OP_WRITE && !we_n_o) |-> !cs_n_o && !address_latch_strobe_o
        && !command_latch_strobe_o && re_n_o)
        else $error("data-in cycle levels wrong");
    a_read_levels: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !re_n_o |-> !cs_n_o && we_n_o && !address_latch_strobe_o
        && !command_latch_strobe_o && !lanes_oe_o)
        else $error("data-out cycle levels wrong");
    a_latch_excl: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !(command_latch_strobe_o && address_latch_strobe_o))
        else $error("both latches high");
    a_strobe_width: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        $fell(we_n_o) |-> !we_n_o [*2])
        else $error("write strobe too short");
    a_upper_lanes: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (lanes_oe_o && st_r.op != OP_WRITE) |-> lanes_o[15:8] == ZERO_BYTE)
        else $error("upper lanes used for command or address");
    // Capture and strobe release share one edge
    a_read_capture: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        $rose(re_n_o) |-> rd_valid_o)
        else $error("read strobe without captured word");

    c_command: cover property (@(posedge clock_i) $rose(we_n_o) && st_r.op == OP_COMMAND);
    c_address: cover property (@(posedge clock_i) $rose(we_n_o) && st_r.op == OP_ADDRESS);
    c_read: cover property (@(posedge clock_i) rd_valid_o);
    c_wide_write: cover property (@(posedge clock_i) $rose(we_n_o) && st_r.op == OP_WRITE && st_r.wide);
endmodule

// ==== tb/nand_dev_model.sv ====
module nand_dev_model #(
    parameter int BUSY_NS = 200,
    parameter int RECOV_NS = 100,
    parameter int ADDR_N = 5
) (
    // Strobes
    input wire logic cs_n_i,
    input wire logic command_latch_strobe_i,
    input wire logic address_latch_strobe_i,
    input wire logic we_n_i,
    input wire logic re_n_i,
    input wire logic write_protect_n_i,
    // Lanes and status
    input wire logic [15:0] lanes_i,
    output logic [15:0] lanes_o,
    output logic ready_busy_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Not a real command code, so a missed capture shows
    logic [7:0] cmd_r = 8'hff;
    logic [15:0] data_r = 16'h0000;
    logic [15:0] q = 16'h0000;
    // Column spans main plus spare region of one page
    logic [11:0] col = 12'h000;
    logic [5:0] page = 6'h00;
    // Wide enough for every block of the larger density
    logic [10:0] blk = 11'h000;
    logic rec = 1'b1;
    logic busy = 1'b0;
    int addr_n = 0;
    int early = 0;
    realtime t_fall = 0;
    initial #(RECOV_NS) rec = 1'b0;
    // Model drives the high level itself, there is no pull-up
    assign ready_busy_n_o = !(rec || busy);
    // Released lanes show the inverse, not a stale copy
    assign lanes_o = (!cs_n_i && !re_n_i) ? q : ~q;
    always @(negedge we_n_i) t_fall = $realtime;
    always @(posedge we_n_i) begin
        if (!cs_n_i && re_n_i && ($realtime - t_fall) >= 5.0) begin
            if (rec) early++;
            if (command_latch_strobe_i && !address_latch_strobe_i) begin
                cmd_r = lanes_i[7:0];
                if (cmd_r == 8'h00 || cmd_r == 8'h80) addr_n = 0;
                if (cmd_r == 8'h30 || (cmd_r == 8'h10 && write_protect_n_i)) begin
                    busy = 1'b1;
                    busy <= #(BUSY_NS) 1'b0;
                end
            end else if (address_latch_strobe_i && !command_latch_strobe_i) begin
                if (addr_n == 0) col[7:0] = lanes_i[7:0];
                if (addr_n == 1) col[11:8] = lanes_i[3:0];
                if (addr_n == 2) {blk[1:0], page} = lanes_i[7:0];
                if (addr_n == 3) blk[9:2] = lanes_i[7:0];
                if (addr_n == 4) blk[10] = lanes_i[0];
                if (addr_n < ADDR_N) addr_n++;
            end else if (!address_latch_strobe_i && !command_latch_strobe_i) begin
                data_r = lanes_i;
                col++;
            end
        end
    end
    always @(negedge re_n_i) begin
        if (!cs_n_i && we_n_i && !command_latch_strobe_i && !address_latch_strobe_i) begin
            q = {4'hc, col};
            col++;
        end
    end
endmodule

// ==== tb/tb_nand_host_ctrl.sv ====
module tb_nand_host_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import nand_host_pkg::*;
    logic clock_i = 0, reset_n_i = 0, req_valid_i = 0, req_last_i = 0, wide_i = 0, protect_i = 0;
    op_type req_op_i = OP_COMMAND;
    logic [15:0] req_data_i = 16'h0000;
    wire req_ready_o, rd_valid_o, ready_o, cs_n_o, command_latch_strobe_o, address_latch_strobe_o;
    wire we_n_o, re_n_o, wp_n_o, oe_o, ready_busy_n;
    wire [15:0] rd_data_o, lanes_o, dev_lanes, lanes;
    int mismatches = 0, tests_run = 0;
    assign lanes = oe_o ? lanes_o : dev_lanes;
    nand_host_ctrl #(.RECOVERY(20)) uut (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .req_valid_i(req_valid_i), .req_op_i(req_op_i), .req_data_i(req_data_i), .req_last_i(req_last_i),
        .wide_i(wide_i), .req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
        .ready_o(ready_o), .protect_i(protect_i), .cs_n_o(cs_n_o),
        .command_latch_strobe_o(command_latch_strobe_o), .address_latch_strobe_o(address_latch_strobe_o),
        .we_n_o(we_n_o), .re_n_o(re_n_o), .write_protect_n_o(wp_n_o),
        .lanes_o(lanes_o), .lanes_oe_o(oe_o), .lanes_i(lanes), .ready_busy_n_i(ready_busy_n));
    nand_dev_model dev (.cs_n_i(cs_n_o), .command_latch_strobe_i(command_latch_strobe_o),
        .address_latch_strobe_i(address_latch_strobe_o),
        .we_n_i(we_n_o), .re_n_i(re_n_o), .write_protect_n_i(wp_n_o), .lanes_i(lanes),
        .lanes_o(dev_lanes), .ready_busy_n_o(ready_busy_n));
    initial begin
        forever #2.5 clock_i = ~clock_i;
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Sel 0 ready_o, 1 rd_valid_o; looked at 1 ns after each edge
    task automatic wait_hi(int sel);
        int n;
        n = 0;
        do begin
            @(posedge clock_i);
            #1;
            n++;
        end while (((sel == 0) ? ready_o : rd_valid_o) !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            mismatches++;
            tally_and_finish();
        end
    endtask
    task automatic send(op_type op, logic [15:0] d, logic last);
        int n;
        logic ok;
        n = 0;
        @(posedge clock_i);
        req_valid_i <= 1'b1;
        req_op_i <= op;
        req_data_i <= d;
        req_last_i <= last;
        do begin
            #1;
            ok = req_ready_o;
            @(posedge clock_i);
            n++;
        end while (ok !== 1'b1 && n < 100);
        req_valid_i <= 1'b0;
        if (n >= 100) begin
            mismatches++;
            tally_and_finish();
        end
    endtask
    ////////////////////////////////////////////////////////////////
    // Called at the third edge of reset; release lands by non-blocking assignment on it
    task automatic t_reset;
        check("cs_n idle", cs_n_o, 1);
        check("we_n idle", we_n_o, 1);
        check("wp_n reset", wp_n_o, 0);
        reset_n_i <= 1'b1;
        repeat (5) @(posedge clock_i);
        #1;
        check("ready in recovery", ready_o, 0);
        wait_hi(0);
        check("early commands", 16'(dev.early), 0);
        check("wp_n released", wp_n_o, 1);
    endtask
    task automatic t_addr_busy;
        send(OP_COMMAND, 16'h0000, 0);
        // Write strobe rises four edges after the request is taken
        repeat (6) @(posedge clock_i);
        check("command byte", dev.cmd_r, 16'h0000);
        send(OP_ADDRESS, 16'h0010, 0);
        send(OP_ADDRESS, 16'h0000, 0);
        for (int i = 0; i < 4; i++) send(OP_ADDRESS, 16'h0001, 0);
        repeat (10) @(posedge clock_i);
        check("address count", 16'(dev.addr_n), 5);
        check("column", dev.col, 16'h0010);
        check("page", dev.page, 16'h0001);
        check("block", dev.blk, 16'h0404);
        send(OP_COMMAND, 16'h0030, 0);
        repeat (12) @(posedge clock_i);
        #1;
        check("busy ready", ready_o, 0);
        wait_hi(0);
    endtask
    task automatic t_read;
        @(posedge clock_i);
        wide_i <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            send(OP_READ, 16'h0000, i == 2);
            wait_hi(1);
            check("read word", rd_data_o, 16'hc010 + 16'(i));
        end
        wait_hi(0);
        check("cs_n after last", cs_n_o, 1);
    endtask
    task automatic t_program;
        send(OP_COMMAND, 16'h0080, 0);
        for (int i = 0; i < 5; i++) send(OP_ADDRESS, 16'h0000, 0);
        send(OP_WRITE, 16'h1234, 0);
        repeat (10) @(posedge clock_i);
        check("write word", dev.data_r, 16'h1234);
        wide_i <= 1'b0;
        send(OP_WRITE, 16'habcd, 0);
        repeat (10) @(posedge clock_i);
        check("narrow write", dev.data_r, 16'h00cd);
        protect_i <= 1'b1;
        @(posedge clock_i);
        #1;
        check("wp_n protect", wp_n_o, 0);
        send(OP_COMMAND, 16'h0010, 1);
        repeat (12) @(posedge clock_i);
        #1;
        check("refused program", ready_o, 1);
        @(posedge clock_i);
        protect_i <= 1'b0;
        send(OP_COMMAND, 16'h0010, 1);
        repeat (12) @(posedge clock_i);
        #1;
        check("program busy", ready_o, 0);
        wait_hi(0);
    endtask
    initial begin
        repeat (3) @(posedge clock_i);
        t_reset();
        t_addr_busy();
        t_read();
        t_program();
        tally_and_finish();
    end
endmodule
